// ===== logic/cpu_core_state.v
/*
 * Programmer-visible state of the CPU core: accumulator, index and
 * short-direct registers on the data-space bus, program counter, three
 * carry/zero flag pairs with context switching, and the return stack.
 * Assumes the instruction decoder presents one operation per instruction
 * and holds it until instr_done_o; data-space accesses are single cycle.
 */
`timescale 1ns/1ps
`include "cpu_core_defs.vh"

module cpu_core_state (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // Data-space bus
  input  wire [7:0]  ds_addr_i,
  input  wire        ds_wr_i,
  input  wire        ds_rd_i,
  input  wire [7:0]  ds_wdata_i,
  output reg  [7:0]  ds_rdata_o,
  output wire        ds_hit_o,
  // Instruction request
  input  wire        instr_valid_i,
  input  wire [3:0]  instr_op_i,
  input  wire [2:0]  instr_cycles_i,
  input  wire [11:0] instr_target_i,
  input  wire [7:0]  instr_offset_i,
  // Flag update request
  input  wire [2:0]  flag_op_i,
  input  wire [8:0]  alu_result_i,
  input  wire        bit_value_i,
  // Instruction status
  output wire        instr_ready_o,
  output reg         instr_done_o,
  output wire        cpu_cycle_o,
  // Core state
  output reg  [11:0] pc_o,
  output wire        carry_o,
  output wire        zero_o,
  output wire [2:0]  mode_o,
  output wire [2:0]  stack_depth_o
);

  // ****************************************************************
  // Modes, one-hot
  // ****************************************************************
  localparam [2:0] MODE_NORMAL = 3'b001;
  localparam [2:0] MODE_IRQ    = 3'b010;
  localparam [2:0] MODE_NMI    = 3'b100;

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [7:0]  accumulator;
  reg  [7:0]  index_pointer_first;
  reg  [7:0]  index_pointer_second;
  reg  [7:0]  short_direct_first;
  reg  [7:0]  short_direct_second;
  reg  [2:0]  mode;
  reg  [2:0]  prior_mode;
  reg  [2:0]  saved_mode;
  reg  [2:0]  carry_flag;
  reg  [2:0]  zero_flag;
  reg  [1:0]  state;
  reg  [2:0]  cyc_left;
  reg  [3:0]  op;
  reg  [11:0] target;
  reg  [7:0]  offset;
  reg  [2:0]  fop;
  reg  [8:0]  result;
  reg         bitval;
  reg  [11:0] next_pc;
  reg         next_c;
  reg         next_z;
  wire [11:0] stack_top;
  wire        stack_empty;
  wire        stack_push;
  wire        stack_pop;
  wire        last_cycle;
  wire [11:0] alu_sum;
  wire        cur_c;
  wire        cur_z;
  wire [1:0]  ctx;

  // ****************************************************************
  // CPU cycle enable
  // ****************************************************************
  cpu_cycle_divider u_div (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cpu_cycle_o (cpu_cycle_o)
  );

  // ****************************************************************
  // Data-space registers
  // ****************************************************************
  assign ds_hit_o = (ds_addr_i == `ADDR_ACCUMULATOR) ||
                    (ds_addr_i == `ADDR_INDEX_FIRST) ||
                    (ds_addr_i == `ADDR_INDEX_SECOND) ||
                    (ds_addr_i == `ADDR_SHORT_FIRST) ||
                    (ds_addr_i == `ADDR_SHORT_SECOND);

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      accumulator          <= 8'h00;
      index_pointer_first  <= 8'h00;
      index_pointer_second <= 8'h00;
      short_direct_first   <= 8'h00;
      short_direct_second  <= 8'h00;
    end else if (ds_wr_i) begin
      case (ds_addr_i)
        `ADDR_ACCUMULATOR:  accumulator          <= ds_wdata_i;
        `ADDR_INDEX_FIRST:  index_pointer_first  <= ds_wdata_i;
        `ADDR_INDEX_SECOND: index_pointer_second <= ds_wdata_i;
        `ADDR_SHORT_FIRST:  short_direct_first   <= ds_wdata_i;
        `ADDR_SHORT_SECOND: short_direct_second  <= ds_wdata_i;
        default: ;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ds_rdata_o <= 8'h00;
    end else if (ds_rd_i) begin
      case (ds_addr_i)
        `ADDR_ACCUMULATOR:  ds_rdata_o <= accumulator;
        `ADDR_INDEX_FIRST:  ds_rdata_o <= index_pointer_first;
        `ADDR_INDEX_SECOND: ds_rdata_o <= index_pointer_second;
        `ADDR_SHORT_FIRST:  ds_rdata_o <= short_direct_first;
        `ADDR_SHORT_SECOND: ds_rdata_o <= short_direct_second;
        default:            ds_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Instruction sequencing
  // ****************************************************************
  assign instr_ready_o = state[0];
  assign last_cycle    = state[1] && cpu_cycle_o && (cyc_left == 3'h1);

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state        <= ST_IDLE;
      cyc_left     <= 3'h0;
      op           <= `OP_NONE;
      target       <= 12'h000;
      offset       <= 8'h00;
      fop          <= `FL_NONE;
      result       <= 9'h000;
      bitval       <= 1'b0;
      instr_done_o <= 1'b0;
    end else begin
      instr_done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (instr_valid_i) begin
            state    <= ST_EXEC;
            op       <= instr_op_i;
            target   <= instr_target_i;
            offset   <= instr_offset_i;
            fop      <= flag_op_i;
            result   <= alu_result_i;
            bitval   <= bit_value_i;
            if (instr_cycles_i == `INSTR_CYC_SHORT || instr_cycles_i == `INSTR_CYC_LONG) begin
              cyc_left <= instr_cycles_i;
            end else begin
              cyc_left <= `INSTR_CYC_MID;
            end
          end
        end
        ST_EXEC: begin
          if (cpu_cycle_o) begin
            cyc_left <= cyc_left - 3'h1;
            if (cyc_left == 3'h1) begin
              state        <= ST_IDLE;
              instr_done_o <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  assign alu_sum    = pc_o + {{4{offset[7]}}, offset};
  assign stack_push = last_cycle && (op == `OP_CALL || op == `OP_IRQ || op == `OP_NMI);
  assign stack_pop  = last_cycle && (op == `OP_RET || op == `OP_RETURN_FROM_INTERRUPT);

  always @* begin
    case (op)
      `OP_JUMP:   next_pc = target;
      `OP_CALL:   next_pc = target;
      `OP_BRANCH: next_pc = alu_sum;
      `OP_IRQ:    next_pc = target;
      `OP_NMI:    next_pc = target;
      `OP_RET:    next_pc = stack_empty ? pc_o + 12'h001 : stack_top;
      `OP_RETURN_FROM_INTERRUPT:   next_pc = stack_empty ? pc_o + 12'h001 : stack_top;
      default:    next_pc = pc_o + 12'h001;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pc_o <= `PC_RESET_VECTOR;
    end else if (last_cycle) begin
      pc_o <= next_pc;
    end
  end

  cpu_return_stack u_stack (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .push_i      (stack_push),
    .pop_i       (stack_pop),
    .push_data_i (pc_o),
    .top_o       (stack_top),
    .empty_o     (stack_empty),
    .depth_o     (stack_depth_o)
  );

  // ****************************************************************
  // Context mode
  // ****************************************************************
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode       <= MODE_NMI;
      prior_mode <= MODE_NORMAL;
      saved_mode <= MODE_NORMAL;
    end else if (last_cycle) begin
      case (op)
        `OP_IRQ: begin
          if (mode == MODE_NORMAL) begin
            prior_mode <= mode;
            mode       <= MODE_IRQ;
          end
        end
        `OP_NMI: begin
          if (mode != MODE_NMI) begin
            saved_mode <= prior_mode;
            prior_mode <= mode;
            mode       <= MODE_NMI;
          end
        end
        `OP_RETURN_FROM_INTERRUPT: begin
          mode       <= prior_mode;
          prior_mode <= saved_mode;
          saved_mode <= MODE_NORMAL;
        end
        default: ;
      endcase
    end
  end

  assign mode_o = mode;
  assign ctx    = mode[2] ? 2'd2 : (mode[1] ? 2'd1 : 2'd0);
  assign cur_c  = carry_flag[ctx];
  assign cur_z  = zero_flag[ctx];
  assign carry_o = cur_c;
  assign zero_o  = cur_z;

  // ****************************************************************
  // Flag pairs
  // ****************************************************************
  always @* begin
    next_c = cur_c;
    next_z = cur_z;
    case (fop)
      `FL_ARITH: begin
        next_c = result[8];
        next_z = (result[7:0] == 8'h00);
      end
      `FL_LOGIC:   next_z = (result[7:0] == 8'h00);
      `FL_BITTEST: next_c = bitval;
      `FL_ROTATE: begin
        next_c = result[8];
        next_z = (result[7:0] == 8'h00);
      end
      default: ;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      carry_flag <= 3'b000;
      zero_flag  <= 3'b000;
    end else if (last_cycle && fop != `FL_NONE) begin
      carry_flag[ctx] <= next_c;
      zero_flag[ctx]  <= next_z;
    end
  end

endmodule // cpu_core_state

// ===== logic/cpu_core_defs.vh
/*
 * Constants for the CPU core state block: data-space addresses of the core
 * registers, program counter reset vector, stack depth and CPU cycle timing.
 * Assumes a single system clock and a synchronous active-low reset.
 */
// Operation
// - 8-bit accumulator for all data work, also data-space location FFh.
// - Two 8-bit index pointers at data-space addresses 80h and 81h.
// - Two 8-bit short-direct registers at 82h and 83h, also direct-addressable.
// - Short-direct and index operands reached by one-byte, four-cycle instruction.
// - Program counter is 12 bits, addressing 4096 program bytes.
// - PC loads jump/call target, adds offset, loads vector, pops, else increments.
// - Relative branch adds PC and offset in the arithmetic unit.
// - Three carry/zero pairs: normal, interrupt, non-maskable; only current used.
// - Interrupt entry selects its pair; return restores the previous pair.
// - Switching pairs never alters any flag value.
// - Instructions touch only the active context's flag pair.
// - Carry set on arithmetic carry or borrow, else cleared.
// - Bit test copies tested bit into carry; rotate-left goes through carry.
// - Zero set when arithmetic or logic result is zero, else cleared.
// - After reset the core runs in non-maskable mode using that pair.
// - Return stack is six 12-bit LIFO levels, no stack pointer.
// - Call or interrupt pushes all levels down, PC enters top, sixth lost.
// - Return loads top level into PC and shifts deeper levels up.
// - Beyond six nested pushes the stack stays full, oldest address lost.
// - Return on empty stack stays at top, execution continues next instruction.
// - CPU cycle is the internal clock divided by 13.
// - Each instruction takes two, four or five CPU cycles.
// - Reset clears the stack and loads PC from reset vector 0FFEh.
`ifndef CPU_CORE_DEFS_VH
`define CPU_CORE_DEFS_VH

// ****************************************************************
// Data-space addresses
// ****************************************************************
`define ADDR_INDEX_FIRST    8'h80
`define ADDR_INDEX_SECOND   8'h81
`define ADDR_SHORT_FIRST    8'h82
`define ADDR_SHORT_SECOND   8'h83
`define ADDR_ACCUMULATOR    8'hFF

// ****************************************************************
// Program counter and stack
// ****************************************************************
`define PC_RESET_VECTOR     12'hFFE
`define STACK_DEPTH         6
`define STACK_CNT_W         3

// ****************************************************************
// Timing
// ****************************************************************
`define CPU_CLK_DIV         13
`define CLK_DIV_W           4
`define INSTR_CYC_SHORT     3'h2
`define INSTR_CYC_MID       3'h4
`define INSTR_CYC_LONG      3'h5

// ****************************************************************
// Instruction operation codes seen by the core
// ****************************************************************
`define OP_NONE             4'h0
`define OP_JUMP             4'h1
`define OP_CALL             4'h2
`define OP_BRANCH           4'h3
`define OP_IRQ              4'h4
`define OP_NMI              4'h5
`define OP_RET              4'h6
`define OP_RETURN_FROM_INTERRUPT             4'h7

// ****************************************************************
// Flag update codes
// ****************************************************************
`define FL_NONE             3'h0
`define FL_ARITH            3'h1
`define FL_LOGIC            3'h2
`define FL_BITTEST          3'h3
`define FL_ROTATE           3'h4

`endif

// ===== logic/cpu_cycle_divider.v
/*
 * Divides the system clock down to the CPU cycle enable pulse.
 * Assumes one system clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "cpu_core_defs.vh"

module cpu_cycle_divider (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  // Enable out
  output reg        cpu_cycle_o
);

  reg [`CLK_DIV_W-1:0] div_cnt;

  // ****************************************************************
  // Divide by thirteen
  // ****************************************************************
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt     <= {`CLK_DIV_W{1'b0}};
      cpu_cycle_o <= 1'b0;
    end else if (div_cnt == `CPU_CLK_DIV - 1) begin
      div_cnt     <= {`CLK_DIV_W{1'b0}};
      cpu_cycle_o <= 1'b1;
    end else begin
      div_cnt     <= div_cnt + 4'h1;
      cpu_cycle_o <= 1'b0;
    end
  end

endmodule // cpu_cycle_divider

// ===== logic/cpu_return_stack.v
/*
 * Six-level 12-bit hardware return stack, shift-register LIFO.
 * Assumes push and pop are never requested in the same cycle.
 */
`timescale 1ns/1ps
`include "cpu_core_defs.vh"

module cpu_return_stack (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // Control
  input  wire        push_i,
  input  wire        pop_i,
  input  wire [11:0] push_data_i,
  // State
  output wire [11:0] top_o,
  output wire        empty_o,
  output reg  [2:0]  depth_o
);

  reg  [11:0] level      [0:`STACK_DEPTH-1];
  wire [11:0] from_upper [0:`STACK_DEPTH-1];
  wire [11:0] from_lower [0:`STACK_DEPTH-1];

  assign top_o   = level[0];
  assign empty_o = (depth_o == 3'h0);

  // ****************************************************************
  // Stack levels
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `STACK_DEPTH; g = g + 1) begin : g_level
      if (g == 0) begin : g_first
        assign from_upper[g] = push_data_i;
      end else begin : g_deeper
        assign from_upper[g] = level[g-1];
      end
      if (g == `STACK_DEPTH - 1) begin : g_last
        assign from_lower[g] = 12'h000;
      end else begin : g_upper
        assign from_lower[g] = level[g+1];
      end
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          level[g] <= 12'h000;
        end else if (push_i) begin
          level[g] <= from_upper[g];
        end else if (pop_i && depth_o != 3'h0) begin
          level[g] <= from_lower[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Occupancy
  // ****************************************************************
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      depth_o <= 3'h0;
    end else if (push_i) begin
      if (depth_o != `STACK_DEPTH) begin
        depth_o <= depth_o + 3'h1;
      end
    end else if (pop_i && depth_o != 3'h0) begin
      depth_o <= depth_o - 3'h1;
    end
  end

endmodule // cpu_return_stack

// ===== tb/cpu_core_state_sva.sv
/* Checker for the core state block: CPU cycle spacing, reset state,
   instruction handshake, state changes and data-space decode.
   Assumes it is bound to the core state block and sees its ports only. */
`timescale 1ns/1ps
`include "cpu_core_defs.vh"

module cpu_core_state_sva (
  // Clock and reset
  input wire        clk_sys_i,
  input wire        rst_n_i,
  // Data-space bus
  input wire [7:0]  ds_addr_i,
  input wire        ds_rd_i,
  input wire [7:0]  ds_rdata_o,
  input wire        ds_hit_o,
  // Instruction status
  input wire        instr_valid_i,
  input wire        instr_ready_o,
  input wire        instr_done_o,
  input wire        cpu_cycle_o,
  // Core state
  input wire [11:0] pc_o,
  input wire [2:0]  mode_o,
  input wire [2:0]  stack_depth_o
);
  reg [3:0] gap;
  reg       seen;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // Clocks since the last CPU cycle pulse
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gap  <= 4'h0;
      seen <= 1'b0;
    end else if (cpu_cycle_o) begin
      gap  <= 4'h0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 4'h1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_cycle_period; cpu_cycle_o && seen |-> gap == 4'hC; endproperty
  a_cycle_period: assert property (p_cycle_period) else $error("cpu cycle spacing wrong");
  property p_cycle_gap; gap <= (seen ? 4'hC : 4'hD); endproperty
  a_cycle_gap: assert property (p_cycle_gap) else $error("cpu cycle pulse missing");
  property p_reset_state;
    disable iff (1'b0) !rst_n_i |=> pc_o == `PC_RESET_VECTOR && mode_o == 3'h4 && stack_depth_o == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_done_pulse; instr_done_o |=> !instr_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_take; instr_valid_i && instr_ready_o |=> !instr_ready_o ##[13:70] instr_done_o; endproperty
  a_take: assert property (p_take) else $error("instruction length wrong");
  property p_pc_hold; !$stable(pc_o) |-> instr_done_o; endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved outside an instruction end");
  property p_ctx_hold; !$stable(mode_o) || !$stable(stack_depth_o) |-> instr_done_o; endproperty
  a_ctx_hold: assert property (p_ctx_hold) else $error("mode or stack moved early");
  property p_depth_max; stack_depth_o <= 3'h6; endproperty
  a_depth_max: assert property (p_depth_max) else $error("stack deeper than six");
  property p_mode_onehot; $onehot(mode_o); endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");
  property p_hit; ds_hit_o == (ds_addr_i[7:2] == 6'h20 || ds_addr_i == 8'hFF); endproperty
  a_hit: assert property (p_hit) else $error("data-space decode wrong");
  property p_unmapped; ds_rd_i && !ds_hit_o |=> ds_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ready_after; instr_done_o |-> ##[0:1] instr_ready_o; endproperty
  a_ready_after: assert property (p_ready_after) else $error("ready not back after done");

  c_full: cover property (instr_done_o && stack_depth_o == 3'h6);
  c_irq: cover property (mode_o == 3'h2);
  c_unmapped: cover property (ds_rd_i && !ds_hit_o);
endmodule // cpu_core_state_sva

// ===== tb/instr_issuer.sv
/* Issuer model: plays the instruction decoder in front of the core.
   Assumes the core's ready, done and CPU cycle outputs as handed over. */
`timescale 1ns/1ps

module instr_issuer (
  // Clock
  input  wire        clk_sys_i,
  // Core status
  input  wire        ready_i,
  input  wire        done_i,
  input  wire        cycle_i,
  // Request
  output reg         valid_o,
  output reg  [3:0]  op_o,
  output reg  [2:0]  cycles_o,
  output reg  [11:0] target_o,
  output reg  [7:0]  offset_o,
  output reg  [2:0]  flag_op_o,
  output reg  [8:0]  result_o,
  output reg         bit_o
);
  initial begin
    {valid_o, op_o, cycles_o, target_o, offset_o, flag_op_o, result_o, bit_o} = 41'h0;
  end

  // Starts after a CPU cycle pulse, holds fields until done, counts pulses
  task issue(input [3:0] op, input [2:0] cyc, input [11:0] tgt, input [7:0] off,
             input [2:0] fop, input [8:0] res, output [7:0] n);
    begin
      n = 8'h00;
      @(posedge clk_sys_i);
      while (!cycle_i) @(posedge clk_sys_i);
      valid_o <= 1'b1;
      {op_o, cycles_o, target_o, offset_o, flag_op_o, result_o, bit_o} <= {op, cyc, tgt, off, fop, res, res[0]};
      @(posedge clk_sys_i);
      while (!ready_i) @(posedge clk_sys_i);
      valid_o <= 1'b0;
      while (!done_i) begin
        @(posedge clk_sys_i);
        if (cycle_i) n = n + 8'h01;
      end
      // Released target, offset, result and bit fields no longer show their last value
      {target_o, offset_o, result_o, bit_o} <= ~{target_o, offset_o, result_o, bit_o};
    end
  endtask
endmodule // instr_issuer

// ===== tb/cpu_core_state_tb.sv
/* Testbench for the core state block: registers, program counter,
   flag pairs, return stack and CPU cycle timing.
   Assumes the issuer model and the bound checker. */
`timescale 1ns/1ps
`include "cpu_core_defs.vh"

module cpu_core_state_tb;
  localparam NRM = 3'h1, IRQ = 3'h2, NMI = 3'h4;
  reg         clk_sys_i, rst_n_i, ds_wr_i, ds_rd_i;
  reg  [7:0]  ds_addr_i, ds_wdata_i, pulses;
  wire [7:0]  ds_rdata_o, off;
  wire        ds_hit_o, valid, ready, done, cycle, bitv, carry, zero;
  wire [3:0]  op;
  wire [2:0]  cyc, fop, mode, depth;
  wire [11:0] tgt, pc;
  wire [8:0]  res;
  integer     bad_count, n_compared, cycle_count, i;

  cpu_core_state i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ds_addr_i(ds_addr_i), .ds_wr_i(ds_wr_i),
    .ds_rd_i(ds_rd_i), .ds_wdata_i(ds_wdata_i), .ds_rdata_o(ds_rdata_o), .ds_hit_o(ds_hit_o),
    .instr_valid_i(valid), .instr_op_i(op), .instr_cycles_i(cyc), .instr_target_i(tgt), .instr_offset_i(off),
    .flag_op_i(fop), .alu_result_i(res), .bit_value_i(bitv), .instr_ready_o(ready), .instr_done_o(done),
    .cpu_cycle_o(cycle), .pc_o(pc), .carry_o(carry), .zero_o(zero), .mode_o(mode), .stack_depth_o(depth));
  instr_issuer i_issuer (.clk_sys_i(clk_sys_i), .ready_i(ready), .done_i(done), .cycle_i(cycle), .valid_o(valid),
    .op_o(op), .cycles_o(cyc), .target_o(tgt), .offset_o(off), .flag_op_o(fop), .result_o(res), .bit_o(bitv));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 6000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task test_done;
    begin
      if (bad_count == 0 && n_compared > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  task chk_data(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk_state(input [19:0] got, input [19:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task ds_write(input [7:0] a, input [7:0] d);
    begin
      ds_wr_i <= 1'b1;
      ds_addr_i <= a;
      ds_wdata_i <= d;
      @(posedge clk_sys_i);
    end
  endtask

  task ds_read(input [7:0] a, input [7:0] exp);
    begin
      ds_rd_i <= 1'b1;
      ds_addr_i <= a;
      @(posedge clk_sys_i);
      ds_rd_i <= 1'b0;
      @(posedge clk_sys_i);
      chk_data(ds_rdata_o, exp);
    end
  endtask

  // One instruction, then pulse count and state {pc, mode, depth, carry, zero}
  task step(input [3:0] o, input [2:0] c, input [11:0] t, input [7:0] f, input [2:0] fo, input [8:0] r,
            input [11:0] e_pc, input [2:0] e_mode, input [2:0] e_dep, input [1:0] e_cz);
    begin
      i_issuer.issue(o, c, t, f, fo, r, pulses);
      chk_data(pulses, (c == 3'h2) ? 8'h02 : (c == 3'h5) ? 8'h05 : 8'h04);
      chk_state({pc, mode, depth, carry, zero}, {e_pc, e_mode, e_dep, e_cz});
    end
  endtask

  task do_reset;
    begin
      rst_n_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      chk_state({pc, mode, depth, carry, zero}, {12'hFFE, NMI, 3'h0, 2'b00});
      rst_n_i <= 1'b1;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n_i, ds_wr_i, ds_rd_i, ds_addr_i, ds_wdata_i} = 19'h0;
    {bad_count, n_compared, cycle_count} = 96'h0;
    do_reset;
    for (i = 0; i < 5; i = i + 1) begin
      ds_write((i == 4) ? 8'hFF : 8'h80 + i[7:0], 8'hA5 ^ i[7:0]);
    end
    ds_write(8'h84, 8'h5A);
    ds_wr_i <= 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      ds_read((i == 4) ? 8'hFF : 8'h80 + i[7:0], 8'hA5 ^ i[7:0]);
    end
    ds_read(8'h84, 8'h00);
    ds_read(8'h7F, 8'h00);
    step(`OP_NONE, 3'h2, 12'h000, 8'h00, `FL_ARITH, 9'h100, 12'hFFF, NMI, 3'h0, 2'b11);
    step(`OP_RETURN_FROM_INTERRUPT, 3'h4, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'h000, NRM, 3'h0, 2'b00);
    step(`OP_JUMP, 3'h5, 12'h123, 8'h00, `FL_NONE, 9'h000, 12'h123, NRM, 3'h0, 2'b00);
    step(`OP_NONE, 3'h4, 12'h000, 8'h00, `FL_LOGIC, 9'h100, 12'h124, NRM, 3'h0, 2'b01);
    step(`OP_NONE, 3'h7, 12'h000, 8'h00, `FL_BITTEST, 9'h0FF, 12'h125, NRM, 3'h0, 2'b11);
    step(`OP_NONE, 3'h2, 12'h000, 8'h00, `FL_ROTATE, 9'h180, 12'h126, NRM, 3'h0, 2'b10);
    step(`OP_BRANCH, 3'h4, 12'h000, 8'hF0, `FL_NONE, 9'h000, 12'h116, NRM, 3'h0, 2'b10);
    step(`OP_BRANCH, 3'h2, 12'h000, 8'h7F, `FL_NONE, 9'h000, 12'h195, NRM, 3'h0, 2'b10);
    step(`OP_CALL, 3'h4, 12'h200, 8'h00, `FL_NONE, 9'h000, 12'h200, NRM, 3'h1, 2'b10);
    step(`OP_IRQ, 3'h5, 12'hFF0, 8'h00, `FL_NONE, 9'h000, 12'hFF0, IRQ, 3'h2, 2'b00);
    step(`OP_NONE, 3'h2, 12'h000, 8'h00, `FL_ARITH, 9'h000, 12'hFF1, IRQ, 3'h2, 2'b01);
    step(`OP_NMI, 3'h5, 12'hFFC, 8'h00, `FL_NONE, 9'h000, 12'hFFC, NMI, 3'h3, 2'b11);
    step(`OP_RETURN_FROM_INTERRUPT, 3'h4, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'hFF1, IRQ, 3'h2, 2'b01);
    step(`OP_RETURN_FROM_INTERRUPT, 3'h4, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'h200, NRM, 3'h1, 2'b10);
    step(`OP_RET, 3'h2, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'h195, NRM, 3'h0, 2'b10);
    for (i = 0; i < 7; i = i + 1) begin
      step(`OP_CALL, 3'h2, 12'h300 + i[11:0], 8'h00, `FL_NONE, 9'h000, 12'h300 + i[11:0], NRM,
           (i < 5) ? i[2:0] + 3'h1 : 3'h6, 2'b10);
    end
    for (i = 0; i < 6; i = i + 1) begin
      step(`OP_RET, 3'h2, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'h305 - i[11:0], NRM,
           3'h5 - i[2:0], 2'b10);
    end
    step(`OP_RET, 3'h5, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'h301, NRM, 3'h0, 2'b10);
    step(`OP_CALL, 3'h4, 12'h400, 8'h00, `FL_NONE, 9'h000, 12'h400, NRM, 3'h1, 2'b10);
    do_reset;
    step(`OP_RET, 3'h2, 12'h000, 8'h00, `FL_NONE, 9'h000, 12'hFFF, NMI, 3'h0, 2'b00);
    test_done;
  end
endmodule // cpu_core_state_tb

bind cpu_core_state cpu_core_state_sva i_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ds_addr_i(ds_addr_i),
  .ds_rd_i(ds_rd_i), .ds_rdata_o(ds_rdata_o), .ds_hit_o(ds_hit_o), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .instr_done_o(instr_done_o), .cpu_cycle_o(cpu_cycle_o), .pc_o(pc_o),
  .mode_o(mode_o), .stack_depth_o(stack_depth_o));
